// ---- hw/ccr_block_map.sv ----
// Address decoder: finds the allocated block and cell of an execution address
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"
module ccr_block_map #(
  parameter int ENT_W = 4
) (
  input  wire ccr_pkg::ccr_map_t         map_in,
  input  wire logic [`CCR_ADDR_W-1:0]    addr_in,
  output logic                           hit_out,
  output logic [2:0]                     blk_out,
  output logic [ENT_W-1:0]               ent_out
);
  import ccr_pkg::*;

  // ****************************************************
  // Block match, any placement of blocks accepted
  // ****************************************************
  // Compare only the bits above the block size
  function automatic logic blk_match(input logic [`CCR_BASE_W-1:0] b, input logic m,
                                     input logic [`CCR_ADDR_W-1:0] a);
    if (m)
      blk_match = (a[`CCR_ADDR_W-1:`CCR_BASE_LSB] == b);
    else
      blk_match = (a[`CCR_ADDR_W-1:`CCR_LSB_INS] == b[`CCR_BASE_W-1:1]);
  endfunction

  // Lowest matching block wins if host overlaps blocks
  always_comb
  begin
    hit_out = 1'b0;
    blk_out = 3'h0;
    for (int i = `CCR_NBLK - 1; i >= 0; i--)
    begin
      if (3'(i) <= map_in.nblk_m1 && blk_match(map_in.base[i], map_in.br_mode, addr_in))  // [RQ6]
      begin
        hit_out = 1'b1;
        blk_out = 3'(i);
      end
    end
    // Cell index from the top bits inside the block
    if (map_in.br_mode)
      ent_out = addr_in[`CCR_LSB_BR-1 -: ENT_W];
    else
      ent_out = addr_in[`CCR_LSB_INS-1 -: ENT_W];
  end
endmodule
`default_nettype wire

// ---- hw/ccr_pkg.sv ----
// Types shared by the code coverage recorder
`include "ccr_regs.svh"
package ccr_pkg;
  // One coverage cell: executed, branch condition met, branch condition not met
  typedef struct packed {
    logic exec;
    logic taken;
    logic ntaken;
  } ccr_cov_t;
  // One observed execution from the emulated processor
  typedef struct packed {
    logic                   vld;
    logic                   br;
    logic                   taken;
    logic [`CCR_ADDR_W-1:0] addr;
  } ccr_evt_t;
  // Block allocation: mode, block count minus one, base per block
  typedef struct packed {
    logic                                  br_mode;
    logic [2:0]                            nblk_m1;
    logic [`CCR_NBLK-1:0][`CCR_BASE_W-1:0] base;
  } ccr_map_t;
  // Host clear range, inclusive
  typedef struct packed {
    logic [`CCR_ADDR_W-1:0] lo;
    logic [`CCR_ADDR_W-1:0] hi;
  } ccr_rng_t;
endpackage

// ---- hw/ccr_recorder.sv ----
// Code coverage recorder: passive capture, block map, retention buffer, break snapshot
//
// Contract
// RQ1 - Capture passively; never stall the processor
// RQ2 - Host view refreshed only at break; the code also zeroes the host view when a reallocation applies the new map
// RQ3 - Span 2 Mbyte instruction, 1 Mbyte with branch
// RQ4 - Instruction mode: 1-8 blocks, 256K aligned
// RQ5 - Branch mode: 1-8 blocks, 128K aligned
// RQ6 - Blocks may be contiguous or scattered
// RQ7 - Reset maps blocks onto program ROM
// RQ8 - Unallocated addresses leave coverage unchanged
// RQ9 - Reallocation first moves data to buffer
// RQ10 - Coverage accumulates until host clears
// RQ11 - Executed flag per instruction address
// RQ12 - Branch met and not-met kept separately
// RQ13 - Host clear zeroes bits in range
`timescale 1ns/1ps
`default_nettype none
`include "ccr_regs.svh"
module ccr_recorder #(
  parameter int ENT_W = 4                           // Cells per block = 2**ENT_W
) (
  input  wire logic                       clk_in,
  input  wire logic                       sys_rst_in,
  input  wire ccr_pkg::ccr_evt_t          evt_in,       // Fetch/branch event, same clock
  input  wire logic                       brk_in,       // Processor at a break (level)
  input  wire logic                       cfg_wr_in,    // New allocation strobe
  input  wire ccr_pkg::ccr_map_t          cfg_in,       // New allocation
  input  wire logic                       clr_in,       // Clear strobe
  input  wire ccr_pkg::ccr_rng_t          clr_rng_in,   // Clear range
  input  wire logic                       rd_buf_in,    // 0 snapshot, 1 retention buffer
  input  wire logic [`CCR_NBLK*(2**ENT_W)>1 ? $clog2(`CCR_NBLK*(2**ENT_W))-1 : 0:0] rd_idx_in,
  output ccr_pkg::ccr_cov_t               rd_data_out,  // Registered read data
  output logic [`CCR_BASE_W-1:0]          rd_base_out,  // Block base of that cell
  output logic                            busy_out      // Reallocation in progress
);
  import ccr_pkg::*;

  // ****************************************************
  // Constants and types
  // ****************************************************
  localparam int NENT  = `CCR_NBLK * (2**ENT_W);    // Total cells
  localparam int IDX_W = $clog2(NENT);

  // Reallocation sequence, one-hot
  typedef enum logic [2:0] {
    CCR_IDLE  = 3'b001,                             // Recording
    CCR_XFER  = 3'b010,                             // Move cells to buffer
    CCR_APPLY = 3'b100                              // Load new map, clear cells
  } ccr_state_t;

  // Reset allocation: consecutive 256K blocks from ROM base
  function automatic ccr_map_t rom_map();
    rom_map.br_mode = `CCR_MODE_RST;
    rom_map.nblk_m1 = 3'h7;
    for (int i = 0; i < `CCR_NBLK; i++)
      rom_map.base[i] = `CCR_ROM_BASE + 7'(2 * i);  // [RQ4] [RQ7]
  endfunction

  // Lowest address covered by cell k under a map
  function automatic logic [`CCR_ADDR_W-1:0] cell_addr(input ccr_map_t m, input int k);
    logic [`CCR_ADDR_W-1:0] a;
    a = '0;
    a[`CCR_ADDR_W-1:`CCR_BASE_LSB] = m.base[k / (2**ENT_W)];
    if (m.br_mode)
      a[`CCR_LSB_BR-1 -: ENT_W] = ENT_W'(k % (2**ENT_W));
    else
    begin
      a[`CCR_BASE_LSB] = 1'b0;                      // 256K alignment forced
      a[`CCR_LSB_INS-1 -: ENT_W] = ENT_W'(k % (2**ENT_W));
    end
    cell_addr = a;
  endfunction

  // Cell lies inside an allocated block and its lowest address lies inside the clear range
  function automatic logic in_clr(input ccr_map_t m, input int k, input ccr_rng_t r);
    logic [`CCR_ADDR_W-1:0] a;
    a = cell_addr(m, k);
    in_clr = (3'(k / (2**ENT_W)) <= m.nblk_m1) && (a >= r.lo) && (a <= r.hi);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  ccr_state_t            st_r, st_nxt;              // Sequence state
  ccr_map_t              map_r, map_nxt;            // Active allocation
  ccr_map_t              pend_r, pend_nxt;          // Allocation waiting to apply
  ccr_map_t              bmap_r, bmap_nxt;          // Allocation the buffer came from
  ccr_cov_t [NENT-1:0]   mem_r, mem_nxt;            // Coverage memory
  ccr_cov_t [NENT-1:0]   buf_r, buf_nxt;            // Retention buffer
  ccr_cov_t [NENT-1:0]   vis_r, vis_nxt;            // Host-visible snapshot
  logic                  brk_d_r;                   // Break level, delayed
  logic                  brk_rise;                  // Break just reached
  logic                  hit;                       // Event inside a block
  logic [2:0]            blk;                       // Matching block
  logic [ENT_W-1:0]      ent;                       // Cell within block
  logic [IDX_W-1:0]      rec_idx;                   // Flat cell index
  logic                  rec;                       // Event is recorded this cycle

  // Address decode of the incoming event
  ccr_block_map #(.ENT_W(ENT_W)) u_map (
    .map_in  (map_r),
    .addr_in (evt_in.addr),
    .hit_out (hit),
    .blk_out (blk),
    .ent_out (ent)
  );

  assign rec_idx  = IDX_W'({blk, ent});
  // Events never back-pressure the processor; cycles spent reallocating drop them
  assign rec      = (st_r == CCR_IDLE) && evt_in.vld && hit;  // [RQ1] [RQ8]
  assign brk_rise = brk_in && !brk_d_r;

  // ****************************************************
  // Next-state logic
  // ****************************************************
  // Clear first, record after, so an event beats a clear in the same cycle
  always_comb
  begin
    st_nxt   = st_r;
    map_nxt  = map_r;
    pend_nxt = pend_r;
    bmap_nxt = bmap_r;
    mem_nxt  = mem_r;
    buf_nxt  = buf_r;
    vis_nxt  = vis_r;
    case (st_r)
      CCR_IDLE:
      begin
        if (clr_in)
        begin
          for (int k = 0; k < NENT; k++)
          begin
            if (in_clr(map_r, k, clr_rng_in))
              mem_nxt[k] = '0;                      // [RQ13]
            if (in_clr(bmap_r, k, clr_rng_in))
              buf_nxt[k] = '0;                      // [RQ13]
          end
        end
        if (rec)
        begin
          mem_nxt[rec_idx].exec = 1'b1;             // [RQ11] [RQ10]
          if (map_r.br_mode && evt_in.br)
          begin
            // Build on the cleared value so a same-cycle clear still drops old outcomes
            mem_nxt[rec_idx].taken  = mem_nxt[rec_idx].taken | evt_in.taken;   // [RQ12]
            mem_nxt[rec_idx].ntaken = mem_nxt[rec_idx].ntaken | !evt_in.taken; // [RQ12]
          end
        end
        if (cfg_wr_in)
        begin
          pend_nxt = cfg_in;
          st_nxt   = CCR_XFER;
        end
      end
      CCR_XFER:
      begin
        // Same map again merges, a new map replaces the old buffer
        for (int k = 0; k < NENT; k++)
          buf_nxt[k] = (bmap_r == map_r) ? (buf_r[k] | mem_r[k]) : mem_r[k];  // [RQ9]
        bmap_nxt = map_r;
        st_nxt   = CCR_APPLY;
      end
      CCR_APPLY:
      begin
        map_nxt = pend_r;                           // [RQ4] [RQ5] [RQ3]
        mem_nxt = '0;                               // [RQ9]
        vis_nxt = '0;
        st_nxt  = CCR_IDLE;
      end
      default:
        st_nxt = CCR_IDLE;
    endcase
    // Snapshot only at a break; running values stay hidden
    if (brk_rise && st_r == CCR_IDLE)
      vis_nxt = mem_r;                              // [RQ2]
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      st_r        <= CCR_IDLE;
      map_r       <= rom_map();                     // [RQ7]
      pend_r      <= rom_map();
      bmap_r      <= rom_map();
      mem_r       <= '0;
      buf_r       <= '0;
      vis_r       <= '0;
      brk_d_r     <= 1'b0;
      rd_data_out <= '0;
      rd_base_out <= '0;
      busy_out    <= 1'b0;
    end
    else
    begin
      st_r        <= st_nxt;
      map_r       <= map_nxt;
      pend_r      <= pend_nxt;
      bmap_r      <= bmap_nxt;
      mem_r       <= mem_nxt;
      buf_r       <= buf_nxt;
      vis_r       <= vis_nxt;
      brk_d_r     <= brk_in;
      rd_data_out <= rd_buf_in ? buf_r[rd_idx_in] : vis_r[rd_idx_in];
      rd_base_out <= rd_buf_in ? bmap_r.base[rd_idx_in[IDX_W-1 -: 3]] : map_r.base[rd_idx_in[IDX_W-1 -: 3]];
      busy_out    <= (st_nxt != CCR_IDLE);
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  sequence seq_realloc;
    busy_out ##1 busy_out ##1 !busy_out;
  endsequence

  a_realloc_steps: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ9]
    (st_r == CCR_IDLE && cfg_wr_in) |=> seq_realloc)
    else $error("reallocation did not take two busy cycles");
  a_xfer_copy: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ9]
    (st_r == CCR_XFER) |=> ((buf_r & $past(mem_r)) == $past(mem_r)))
    else $error("coverage not moved into buffer");
  a_apply_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ9]
    (st_r == CCR_APPLY) |=> (mem_r == '0 && map_r == $past(pend_r)))
    else $error("new map not applied or memory not cleared");
  a_miss_ignored: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ8]
    (st_r == CCR_IDLE && evt_in.vld && !hit && !clr_in && !brk_rise) |=> $stable(mem_r))
    else $error("unallocated address changed coverage");
  a_hit_exec: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ11]
    rec |=> mem_r[$past(rec_idx)].exec)
    else $error("executed flag not set");
  a_branch_split: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ12]
    (rec && map_r.br_mode && evt_in.br) |=>
      ($past(evt_in.taken) ? mem_r[$past(rec_idx)].taken : mem_r[$past(rec_idx)].ntaken))
    else $error("branch outcome not recorded");
  a_accumulate: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ10]
    (st_r == CCR_IDLE && !clr_in) |=> ((mem_r & $past(mem_r)) == $past(mem_r)))
    else $error("coverage lost without a clear");
  a_snap_break: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ2]
    (st_r == CCR_IDLE && brk_rise) |=> (vis_r == $past(mem_r)))
    else $error("snapshot not taken at break");
  a_snap_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)  // [RQ2]
    (st_r == CCR_IDLE && !brk_rise) |=> $stable(vis_r))
    else $error("host view changed while running");
  a_reset_rom: assert property (@(posedge clk_in)  // [RQ7]
    $fell(sys_rst_in) |-> (map_r == rom_map()))
    else $error("reset map is not the ROM map");
endmodule
`default_nettype wire

// ---- hw/ccr_regs.svh ----
// Constants for the code coverage recorder: widths, alignment and reset values
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
// Execution address width (16 Mbyte space)
`define CCR_ADDR_W    24
// Number of mappable blocks
`define CCR_NBLK      8
// Block base keeps address bits 23:17 (128-Kbyte granule)
`define CCR_BASE_W    7
`define CCR_BASE_LSB  17
// Block size exponent: instruction only 256 Kbyte, with branches 128 Kbyte
`define CCR_LSB_INS   18
`define CCR_LSB_BR    17
// Program ROM base, as a block-base index, used after reset
`define CCR_ROM_BASE  7'h00
// Reset mode: instruction coverage only
`define CCR_MODE_RST  1'b0
`endif

// ---- testbench/ccr_cpu_model.sv ----
// Emulated processor model: issues execution events and breaks to the recorder
`timescale 1ns/1ps
`default_nettype none
module ccr_cpu_model (
  input  wire logic              clk_in,
  output var  ccr_pkg::ccr_evt_t evt_out,
  output logic                   brk_out
);
  import ccr_pkg::*;
  // ****************************************
  // Idle state at time zero
  // ****************************************
  initial
  begin
    evt_out = '0;
    brk_out = 1'b0;
  end
  // ****************************************
  // Bus actions
  // ****************************************
  // One executed instruction; no stall input exists, the core never waits
  task automatic exec(input logic [23:0] a, input logic br, input logic tk);
    @(posedge clk_in);
    evt_out <= '{vld: 1'b1, br: br, taken: tk, addr: a};
  endtask
  // Released qualifiers flip so a stale address is never mistaken for a live one
  task automatic idle();
    @(posedge clk_in);
    evt_out <= '{vld: 1'b0, br: ~evt_out.br, taken: ~evt_out.taken, addr: ~evt_out.addr};
  endtask
  // Break: raise, give the snapshot two edges, then resume
  task automatic brk();
    @(posedge clk_in);
    brk_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    brk_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/ccr_recorder_test.sv ----
// Self-checking testbench for the code coverage recorder
`timescale 1ns/1ps
`default_nettype none
module ccr_recorder_test;
  import ccr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic       clk_in;      // 40 MHz clock
  logic       sys_rst_in;  // Synchronous reset
  ccr_evt_t   evt;         // Events from the core model
  logic       brk;         // Break level from the core model
  logic       cfg_wr_in;   // Allocation strobe
  ccr_map_t   cfg_in;      // Allocation
  logic       clr_in;      // Clear strobe
  ccr_rng_t   clr_rng_in;  // Clear range
  logic       rd_buf_in;   // Read source select
  logic [6:0] rd_idx_in;   // Read cell index
  ccr_cov_t   rd_data_out; // Read cell bits
  logic [6:0] rd_base_out; // Read block base
  logic       busy_out;    // Reallocation flag
  int         mismatches;  // Failed comparisons
  int         checks;      // All comparisons
  // ****************************************
  // Clock and instances
  // ****************************************
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  ccr_cpu_model cpu (.clk_in(clk_in), .evt_out(evt), .brk_out(brk));
  ccr_recorder #(.ENT_W(4)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .evt_in(evt), .brk_in(brk),
    .cfg_wr_in(cfg_wr_in), .cfg_in(cfg_in), .clr_in(clr_in), .clr_rng_in(clr_rng_in),
    .rd_buf_in(rd_buf_in), .rd_idx_in(rd_idx_in), .rd_data_out(rd_data_out),
    .rd_base_out(rd_base_out), .busy_out(busy_out));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Cell start address: base granule plus cell offset (shift 14 instruction, 13 branch)
  function automatic logic [23:0] adr(input logic [6:0] b, input int c, input int sh);
    return {b, 17'h0} + 24'(c << sh);
  endfunction
  // Registered read: index at one edge, data one edge later; cb off skips the base
  task automatic rd(input logic b, input logic [6:0] i, input logic [2:0] d, input logic [6:0] bs,
                    input logic cb = 1'b1);
    @(posedge clk_in);
    rd_buf_in <= b;
    rd_idx_in <= i;
    @(posedge clk_in);
    #1;
    check({13'h0, rd_data_out}, {13'h0, d});
    if (cb)
      check({9'h0, rd_base_out}, {9'h0, bs});
  endtask
  // Allocation change; busy must stand exactly two cycles
  task automatic set_map(input ccr_map_t m);
    int n;
    n = 0;
    @(posedge clk_in);
    cfg_in    <= m;
    cfg_wr_in <= 1'b1;
    @(posedge clk_in);
    cfg_wr_in <= 1'b0;
    #1;
    while (busy_out !== 1'b0)
    begin
      @(posedge clk_in);
      #1;
      n++;
      if (n > 8)
      begin
        mismatches++;
        summarize();
      end
    end
    check(16'(n), 16'h2);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Reset map covers program ROM from address zero, cells empty
  task automatic t_rom();
    for (int i = 0; i < 8; i++)
      rd(1'b0, 7'(i * 16), 3'h0, 7'(2 * i));
    $display("test rom map done");
  endtask
  // Instruction mode: span ends, unallocated address, branch bits ignored
  task automatic t_exec();
    cpu.exec(adr(7'h00, 0, 14), 1'b0, 1'b0);
    cpu.exec(24'h1fffff, 1'b0, 1'b0);
    cpu.exec(24'h204000, 1'b0, 1'b0); // Aliases onto cell 1 if the top bits were ignored
    cpu.exec(adr(7'h04, 3, 14), 1'b1, 1'b1);
    cpu.idle();
    rd(1'b0, 7'h00, 3'h0, 7'h00);
    cpu.brk();
    rd(1'b0, 7'h00, 3'h4, 7'h00);
    rd(1'b0, 7'h7f, 3'h4, 7'h0e);
    rd(1'b0, 7'h23, 3'h4, 7'h04);
    rd(1'b0, 7'h01, 3'h0, 7'h00);
    $display("test instruction coverage done");
  endtask
  // Branch mode with four blocks, two contiguous and two scattered; old data moves to the buffer
  task automatic t_branch();
    ccr_map_t m;
    m.br_mode = 1'b1;
    m.nblk_m1 = 3'h3;
    for (int i = 0; i < 8; i++)
      m.base[i] = (i < 2) ? 7'(8'h40 + i) : 7'(8'h50 + 3 * i);
    set_map(m);
    rd(1'b1, 7'h00, 3'h4, 7'h00);
    rd(1'b1, 7'h7f, 3'h4, 7'h0e);
    rd(1'b0, 7'h00, 3'h0, 7'h40);
    cpu.exec(adr(7'h40, 0, 13), 1'b0, 1'b0);
    cpu.exec(adr(7'h40, 1, 13), 1'b1, 1'b1);
    cpu.exec(adr(7'h40, 1, 13), 1'b1, 1'b0);
    cpu.exec(adr(7'h41, 2, 13), 1'b1, 1'b1);
    cpu.exec(adr(7'h56, 15, 13) + 24'h1fff, 1'b1, 1'b0);
    cpu.exec(adr(7'h5c, 0, 13), 1'b0, 1'b0);
    cpu.idle();
    cpu.brk();
    rd(1'b0, 7'h00, 3'h4, 7'h40);
    rd(1'b0, 7'h01, 3'h7, 7'h40);
    rd(1'b0, 7'h12, 3'h6, 7'h41);
    rd(1'b0, 7'h2f, 3'h5, 7'h56);
    rd(1'b0, 7'h40, 3'h0, 7'h5c);
    $display("test branch coverage done");
  endtask
  // Second run adds to the first; a range clear hits one cell only
  task automatic t_clear();
    cpu.exec(adr(7'h41, 2, 13), 1'b1, 1'b0);
    cpu.idle();
    cpu.brk();
    rd(1'b0, 7'h12, 3'h7, 7'h41);
    @(posedge clk_in);
    clr_rng_in <= '{lo: adr(7'h40, 0, 13), hi: adr(7'h40, 0, 13) + 24'h1fff};
    clr_in     <= 1'b1;
    @(posedge clk_in);
    clr_in <= 1'b0;
    cpu.brk();
    rd(1'b0, 7'h00, 3'h0, 7'h40);
    rd(1'b0, 7'h01, 3'h7, 7'h40);
    rd(1'b1, 7'h00, 3'h4, 7'h00);
    $display("test clear done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    mismatches = 0;
    checks     = 0;
    sys_rst_in = 1'b1;
    cfg_wr_in  = 1'b0;
    cfg_in     = '0;
    clr_in     = 1'b0;
    clr_rng_in = '0;
    rd_buf_in  = 1'b0;
    rd_idx_in  = 7'h00;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_rom();
    t_exec();
    t_branch();
    t_clear();
    summarize();
  end
endmodule
`default_nettype wire
